// [rtl/cbac_top.sv]
// Bus cycle attribute control: line fill, bus sizing, page attributes.
`timescale 1ns/10ps
`include "cbac_defs.svh"
module cbac_top (
    input wire logic clk, // 125 MHz clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic req_valid, // Core bus request
    input wire logic [31:0] req_addr, // Request byte address
    input wire logic [3:0] req_be, // Request byte lanes, active high
    input wire logic req_read, // Request is a read
    input wire logic req_untranslated, // Cycle bypasses paging
    input wire logic paging_en, // Paging enabled
    input wire logic [11:0] page_entry, // Governing page table entry
    input wire logic [11:0] page_base_ctl, // Page-base control register
    input wire logic fill_disable_bit, // Cache fill disable in reg zero
    input wire logic bus_granted, // Bus given to another master
    input wire logic rdy_n, // Transfer ready, active low
    input wire logic cacheable_resp_n, // Cacheable response, active low
    input wire logic width_half_sel_n, // 16-bit bus select, active low
    input wire logic width_byte_sel_n, // 8-bit bus select, active low
    input wire logic addr_bit20_mask_n, // Bit 20 mask, active low
    input wire logic flush_n, // Cache flush, active low
    input wire logic inv_strobe_n, // External invalidate strobe, low
    input wire logic [31:4] inv_addr, // External invalidate address
    output logic req_ready, // Ready for a new request
    output logic address_strobe_n, // Address strobe, active low
    output logic [31:2] addr_out, // Bus word address
    output logic [3:0] byte_en_n, // Bus byte enables, active low
    output logic page_write_through, // Write-through attribute
    output logic pwt_oe, // Drive enable of write-through
    output logic page_cache_disable, // Cache-disable attribute
    output logic pcd_oe, // Drive enable of cache-disable
    output logic fill_active, // Line fill in progress
    output logic xfer_ack, // One transfer completed, pulse
    output cbac_pkg::cbac_width_t xfer_width, // Width of that transfer
    output logic req_done, // Whole request complete, pulse
    output logic cache_flush, // Invalidate whole cache, pulse
    output logic lookup_valid, // Cache lookup strobe, pulse
    output logic [31:2] lookup_addr, // Cache lookup address
    output logic inv_valid, // Invalidation strobe, pulse
    output logic [31:4] inv_addr_out // Unmasked invalidate address
);
    import cbac_pkg::*;

    // ======================================================================
    // Functions
    // ======================================================================
    function automatic cbac_width_t width_of(input logic half_n,
                                             input logic byte_n);
        if (!byte_n) begin
            width_of = CBAC_W8;
        end else if (!half_n) begin
            width_of = CBAC_W16;
        end else begin
            width_of = CBAC_W32;
        end
    endfunction

    function automatic logic [4:0] bytes_of(input cbac_width_t w);
        case (w)
            CBAC_W16: bytes_of = `CBAC_BYTES_W16;
            CBAC_W8: bytes_of = `CBAC_BYTES_W8;
            default: bytes_of = `CBAC_BYTES_W32;
        endcase
    endfunction

    // Lanes that one transfer of the given width covers out of rem.
    function automatic logic [3:0] lanes_cov(input cbac_width_t w,
                                             input logic [3:0] rem);
        case (w)
            CBAC_W16: lanes_cov = (|(rem & `CBAC_LANES_LO)) ?
                                  (rem & `CBAC_LANES_LO) :
                                  (rem & `CBAC_LANES_HI);
            CBAC_W8: lanes_cov = rem & (~rem + `CBAC_LANE0);
            default: lanes_cov = rem;
        endcase
    endfunction

    // Lanes of a fill transfer at a byte offset for a width.
    function automatic logic [3:0] fill_lanes(input cbac_width_t w,
                                              input logic [1:0] off);
        case (w)
            CBAC_W16: fill_lanes = off[1] ? `CBAC_LANES_HI :
                                            `CBAC_LANES_LO;
            CBAC_W8: fill_lanes = `CBAC_LANE0 << off;
            default: fill_lanes = `CBAC_ALL_LANES;
        endcase
    endfunction

    function automatic logic [31:0] mask20(input logic [31:0] a,
                                           input logic m);
        mask20 = a;
        mask20[`CBAC_A20_BIT] = a[`CBAC_A20_BIT] & ~m;
    endfunction

    // ======================================================================
    // Mask latency stage
    // ======================================================================
    cbac_mask_if mask_if ();

    cbac_a20_lat u_a20 (
        .clk(clk),
        .rst_b(rst_b),
        .addr_bit20_mask_n(addr_bit20_mask_n),
        .mask_if(mask_if)
    );

    // ======================================================================
    // Pin samplers
    // ======================================================================
    cbac_width_t wsel_q, wsel_d;
    logic ken_q, ken_d;
    logic flush_q, flush_d;
    logic inv_v_q, inv_v_d;
    logic [31:4] inv_a_q, inv_a_d;
    logic oe_q, oe_d;

    always_comb begin
        wsel_d = width_of(width_half_sel_n, width_byte_sel_n);
        ken_d = ~cacheable_resp_n;
        flush_d = ~flush_n;
        inv_v_d = ~inv_strobe_n;
        inv_a_d = inv_strobe_n ? inv_a_q : inv_addr;
        oe_d = ~bus_granted;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wsel_q <= CBAC_W32;
            ken_q <= 1'b0;
            flush_q <= 1'b0;
            inv_v_q <= 1'b0;
            inv_a_q <= '0;
            oe_q <= 1'b0;
        end else begin
            wsel_q <= wsel_d;
            ken_q <= ken_d;
            flush_q <= flush_d;
            inv_v_q <= inv_v_d;
            inv_a_q <= inv_a_d;
            oe_q <= oe_d;
        end
    end

    // ======================================================================
    // Cycle sequencer
    // ======================================================================
    cbac_state_t st_q, st_d;
    logic [31:0] base_q, base_d;
    logic [3:0] rem_q, rem_d;
    logic rd_q, rd_d, fok_q, fok_d, fill_q, fill_d, first_q, first_d;
    logic mcyc_q, mcyc_d, pwt_q, pwt_d, pcd_q, pcd_d;
    logic [4:0] cnt_q, cnt_d, nx_q, nx_d;
    logic [3:0] off_q, off_d;
    logic ads_q, ads_d, ack_q, ack_d, done_q, done_d, lv_q, lv_d;
    logic [31:2] ao_q, ao_d, la_q, la_d;
    logic [3:0] ben_q, ben_d;
    cbac_width_t xw_q, xw_d;
    logic [1:0] attr;
    logic [31:0] ma;
    logic [3:0] cov;
    logic [4:0] nb;
    logic rr_q, rr_d;

    always_comb begin
        attr = 2'b00;
        if (paging_en) begin
            attr = req_untranslated ?
                   page_base_ctl[`CBAC_PCD_BIT:`CBAC_PWT_BIT] :
                   page_entry[`CBAC_PCD_BIT:`CBAC_PWT_BIT];
        end
        ma = mask20(req_addr, mask_if.mask_eff);
        cov = lanes_cov(wsel_q, rem_q);
        nb = bytes_of(wsel_q);
        st_d = st_q;
        base_d = base_q;
        rem_d = rem_q;
        rd_d = rd_q;
        fok_d = fok_q;
        fill_d = fill_q;
        first_d = first_q;
        mcyc_d = mcyc_q;
        pwt_d = pwt_q;
        pcd_d = pcd_q;
        cnt_d = cnt_q;
        off_d = off_q;
        nx_d = nx_q;
        ads_d = 1'b0;
        ack_d = 1'b0;
        done_d = 1'b0;
        lv_d = 1'b0;
        ao_d = ao_q;
        la_d = la_q;
        ben_d = ben_q;
        xw_d = xw_q;
        case (st_q)
            CBAC_IDLE: begin
                if (req_valid && !bus_granted) begin
                    st_d = CBAC_ADDR;
                    base_d = ma;
                    mcyc_d = mask_if.mask_eff;
                    rem_d = req_be;
                    rd_d = req_read;
                    pwt_d = attr[0];
                    pcd_d = attr[1] | fill_disable_bit;
                    fok_d = req_read && !attr[1] &&
                            !fill_disable_bit;
                    fill_d = 1'b0;
                    first_d = 1'b1;
                    cnt_d = '0;
                    nx_d = '0;
                    ads_d = 1'b1;
                    ao_d = ma[31:2];
                    ben_d = ~req_be;
                    lv_d = 1'b1;
                    la_d = ma[31:2];
                end
            end
            CBAC_ADDR: begin
                st_d = CBAC_DATA;
            end
            CBAC_DATA: begin
                if (!rdy_n) begin
                    ack_d = 1'b1;
                    xw_d = wsel_q;
                    first_d = 1'b0;
                    st_d = CBAC_ADDR;
                    ads_d = 1'b1;
                    if (fill_q || (first_q && rd_q && fok_q && ken_q)) begin
                        fill_d = 1'b1;
                        nx_d = nx_q + 5'h01;
                        cnt_d = cnt_q + nb;
                        off_d = (fill_q ? off_q : {base_q[3:2], 2'b00}) +
                                nb[3:0];
                        ao_d = {base_q[31:4], off_d[3:2]};
                        ben_d = ~fill_lanes(wsel_q, off_d[1:0]);
                        if (cnt_d >= `CBAC_LINE_BYTES) begin
                            st_d = CBAC_IDLE;
                            ads_d = 1'b0;
                            fill_d = 1'b0;
                            done_d = 1'b1;
                        end
                    end else begin
                        rem_d = rem_q & ~cov;
                        ben_d = ~rem_d;
                        if (rem_d == `CBAC_NO_LANES) begin
                            st_d = CBAC_IDLE;
                            ads_d = 1'b0;
                            done_d = 1'b1;
                        end
                    end
                end
            end
            default: begin
                st_d = CBAC_IDLE;
            end
        endcase
        rr_d = (st_d == CBAC_IDLE) && !lv_d;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= CBAC_IDLE;
            base_q <= '0;
            rem_q <= '0;
            rd_q <= 1'b0;
            fok_q <= 1'b0;
            fill_q <= 1'b0;
            first_q <= 1'b0;
            mcyc_q <= 1'b0;
            pwt_q <= 1'b0;
            pcd_q <= 1'b0;
            cnt_q <= '0;
            off_q <= '0;
            nx_q <= '0;
            ads_q <= 1'b0;
            ack_q <= 1'b0;
            done_q <= 1'b0;
            lv_q <= 1'b0;
            ao_q <= '0;
            la_q <= '0;
            ben_q <= `CBAC_ALL_LANES;
            xw_q <= CBAC_W32;
            rr_q <= 1'b1;
        end else begin
            st_q <= st_d;
            base_q <= base_d;
            rem_q <= rem_d;
            rd_q <= rd_d;
            fok_q <= fok_d;
            fill_q <= fill_d;
            first_q <= first_d;
            mcyc_q <= mcyc_d;
            pwt_q <= pwt_d;
            pcd_q <= pcd_d;
            cnt_q <= cnt_d;
            off_q <= off_d;
            nx_q <= nx_d;
            ads_q <= ads_d;
            ack_q <= ack_d;
            done_q <= done_d;
            lv_q <= lv_d;
            ao_q <= ao_d;
            la_q <= la_d;
            ben_q <= ben_d;
            xw_q <= xw_d;
            rr_q <= rr_d;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign req_ready = rr_q;
    assign address_strobe_n = ~ads_q;
    assign addr_out = ao_q;
    assign byte_en_n = ben_q;
    assign page_write_through = pwt_q;
    assign page_cache_disable = pcd_q;
    assign pwt_oe = oe_q;
    assign pcd_oe = oe_q;
    assign fill_active = fill_q;
    assign xfer_ack = ack_q;
    assign xfer_width = xw_q;
    assign req_done = done_q;
    assign cache_flush = flush_q;
    assign lookup_valid = lv_q;
    assign lookup_addr = la_q;
    assign inv_valid = inv_v_q;
    assign inv_addr_out = inv_a_q;

    // ======================================================================
    // Checks
    // ======================================================================
    sequence s_strobe;
        !address_strobe_n;
    endsequence

    sequence s_fill_end;
        fill_q ##1 !fill_q;
    endsequence

    property p_fill_cause;
        @(posedge clk) disable iff (!rst_b)
        $rose(fill_q) |-> $past(ken_q) && rd_q && !pcd_q;
    endproperty
    a_fill_cause: assert property (p_fill_cause)
        else $error("line fill without cacheable read");

    property p_fill_bytes;
        @(posedge clk) disable iff (!rst_b)
        s_fill_end |-> cnt_q == `CBAC_LINE_BYTES && done_q;
    endproperty
    a_fill_bytes: assert property (p_fill_bytes)
        else $error("line fill ended short of a full line");

    property p_fill_xfers;
        @(posedge clk) disable iff (!rst_b)
        s_fill_end |-> nx_q >= `CBAC_FILL_MIN_XFERS &&
                       nx_q <= `CBAC_FILL_MAX_XFERS;
    endproperty
    a_fill_xfers: assert property (p_fill_xfers)
        else $error("line fill transfer count out of range");

    property p_flush;
        @(posedge clk) disable iff (!rst_b)
        !flush_n |=> cache_flush;
    endproperty
    a_flush: assert property (p_flush)
        else $error("single flush clock not honoured");

    property p_attr;
        @(posedge clk) disable iff (!rst_b)
        st_q == CBAC_IDLE && req_valid && !bus_granted |=>
            page_write_through == $past(attr[0]) &&
            page_cache_disable == ($past(attr[1]) | $past(fill_disable_bit));
    endproperty
    a_attr: assert property (p_attr)
        else $error("page attribute outputs wrong");

    property p_float;
        @(posedge clk) disable iff (!rst_b)
        bus_granted |=> !pwt_oe && !pcd_oe;
    endproperty
    a_float: assert property (p_float)
        else $error("attributes driven while bus granted");

    property p_width;
        @(posedge clk) disable iff (!rst_b)
        st_q == CBAC_DATA && !rdy_n |=> xfer_width == $past(wsel_q);
    endproperty
    a_width: assert property (p_width)
        else $error("transfer width not taken before ready");

    property p_both_sel;
        @(posedge clk) disable iff (!rst_b)
        !width_half_sel_n && !width_byte_sel_n |=> wsel_q == CBAC_W8;
    endproperty
    a_both_sel: assert property (p_both_sel)
        else $error("both size inputs did not select 8 bits");

    property p_split8;
        @(posedge clk) disable iff (!rst_b)
        st_q == CBAC_DATA && !fill_q && wsel_q == CBAC_W8 &&
            rem_q != `CBAC_NO_LANES |-> $onehot(cov);
    endproperty
    a_split8: assert property (p_split8)
        else $error("8-bit transfer covers more than one lane");

    property p_mask_addr;
        @(posedge clk) disable iff (!rst_b)
        s_strobe and mcyc_q |-> !addr_out[`CBAC_A20_BIT];
    endproperty
    a_mask_addr: assert property (p_mask_addr)
        else $error("bit 20 not masked on external cycle");

    property p_inv;
        @(posedge clk) disable iff (!rst_b)
        !inv_strobe_n |=> inv_valid && inv_addr_out == $past(inv_addr);
    endproperty
    a_inv: assert property (p_inv)
        else $error("invalidation address altered");

    property p_mask_hold;
        @(posedge clk) disable iff (!rst_b)
        st_q != CBAC_IDLE && $past(st_q) != CBAC_IDLE |-> $stable(mcyc_q);
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("mask changed inside a running cycle");
endmodule

// [rtl/cbac_defs.svh]
// Shared constants for the bus cycle attribute control block.
`ifndef CBAC_DEFS_SVH
`define CBAC_DEFS_SVH

// ==========================================================================
// Attribute bit positions and address bit 20 position
// ==========================================================================
`define CBAC_PWT_BIT 3
`define CBAC_PCD_BIT 4
`define CBAC_A20_BIT 20

// ==========================================================================
// Line fill and bus sizing
// ==========================================================================
`define CBAC_LINE_BYTES 5'h10
`define CBAC_FILL_MIN_XFERS 5'h04
`define CBAC_FILL_MAX_XFERS 5'h10
`define CBAC_BYTES_W32 5'h04
`define CBAC_BYTES_W16 5'h02
`define CBAC_BYTES_W8 5'h01
`define CBAC_ALL_LANES 4'hf
`define CBAC_NO_LANES 4'h0
`define CBAC_LANES_LO 4'h3
`define CBAC_LANES_HI 4'hc
`define CBAC_LANE0 4'h1

// ==========================================================================
// Address bit 20 mask latency, in clocks
// ==========================================================================
`define CBAC_A20_LAT 4

`endif

// [rtl/cbac_pkg.sv]
// Types shared by the bus cycle attribute control block.
package cbac_pkg;
    typedef enum logic [1:0] {
        CBAC_W32,
        CBAC_W16,
        CBAC_W8
    } cbac_width_t;

    typedef enum logic [1:0] {
        CBAC_IDLE,
        CBAC_ADDR,
        CBAC_DATA
    } cbac_state_t;
endpackage

// [rtl/cbac_mask_if.sv]
// Carries the delayed address bit 20 mask level between the two modules.
`timescale 1ns/10ps
interface cbac_mask_if;
    logic mask_eff;

    modport src (output mask_eff);
    modport dst (input mask_eff);
endinterface

// [rtl/cbac_a20_lat.sv]
// Latency stage for the address bit 20 mask input.
`timescale 1ns/10ps
`include "cbac_defs.svh"
module cbac_a20_lat (
    input wire logic clk, // 125 MHz clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic addr_bit20_mask_n, // Mask request pin, active low
    cbac_mask_if.src mask_if // Delayed mask level
);
    import cbac_pkg::*;

    logic [`CBAC_A20_LAT-1:0] sh_q;
    logic [`CBAC_A20_LAT-1:0] sh_d;

    // ======================================================================
    // Delay line
    // ======================================================================
    always_comb begin
        sh_d = {sh_q[`CBAC_A20_LAT-2:0], ~addr_bit20_mask_n};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end

    assign mask_if.mask_eff = sh_q[`CBAC_A20_LAT-1];

    // ======================================================================
    // Checks
    // ======================================================================
    property p_mask_latency;
        @(posedge clk) disable iff (!rst_b)
        mask_if.mask_eff |-> $past(!addr_bit20_mask_n, `CBAC_A20_LAT);
    endproperty
    a_mask_latency: assert property (p_mask_latency)
        else $error("mask took effect earlier than four clocks");
endmodule

// [tb/cbac_mem_model.sv]
// Memory controller model that answers bus cycles of the block.
`timescale 1ns/10ps
module cbac_mem_model (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic address_strobe_n, // Strobe from the block
    input wire logic [1:0] cfg_w, // 0 is 32, 1 is 16, 2 is 8, 3 both
    input wire logic [2:0] dly, // Wait clocks before ready
    output logic rdy_n, // Ready, active low
    output logic width_half_sel_n, // 16-bit select
    output logic width_byte_sel_n // 8-bit select
);
    logic [2:0] cnt_q;
    // ==========================================================
    // Size selects
    // Data lanes are not modelled; every lane counts as valid.
    assign width_half_sel_n = !cfg_w[0];
    assign width_byte_sel_n = !cfg_w[1];
    // ==========================================================
    // Ready after a programmable wait
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 3'h0;
            rdy_n <= 1'b1;
        end else begin
            rdy_n <= 1'b1;
            if (!address_strobe_n) begin
                cnt_q <= dly;
            end else if (cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
                rdy_n <= !(cnt_q == 3'h1);
            end
        end
    end
endmodule

// [tb/cbac_top_tb.sv]
// Self-checking bench for the bus cycle attribute control block.
`timescale 1ns/10ps
module cbac_top_tb;
    import cbac_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_read = 1'b0;
    logic req_untranslated = 1'b0, paging_en = 1'b0, bus_granted = 1'b0;
    logic fill_disable_bit = 1'b0, cacheable_resp_n = 1'b1, flush_n = 1'b1;
    logic addr_bit20_mask_n = 1'b1, inv_strobe_n = 1'b1;
    logic [31:0] req_addr = 32'h0;
    logic [3:0] req_be = 4'hf;
    logic [11:0] page_entry = 12'h0, page_base_ctl = 12'h0;
    logic [31:4] inv_addr = 28'h0;
    logic [1:0] cfg_w = 2'h0;
    logic [2:0] dly = 3'h1;
    logic rdy_n, width_half_sel_n, width_byte_sel_n, req_ready, saw_fill;
    logic address_strobe_n, page_write_through, pwt_oe, page_cache_disable;
    logic pcd_oe, fill_active, xfer_ack, req_done, cache_flush;
    logic lookup_valid, inv_valid;
    logic [3:0] byte_en_n, be2;
    logic [31:4] inv_addr_out;
    logic [31:2] addr_out, lookup_addr, la;
    cbac_width_t xfer_width, lw;
    int n_fail = 0, tests_run = 0, n_ack;
    int fl[4] = '{4, 8, 16, 16};
    int sp[4] = '{1, 2, 4, 4};
    // Active-low enables left for the second transfer of a split write.
    logic [3:0] eb[4] = '{4'hf, 4'h3, 4'h1, 4'h1};
    cbac_width_t ew[4] = '{CBAC_W32, CBAC_W16, CBAC_W8, CBAC_W8};
    // Fields: paging, untranslated, fill off, entry 4:3, base 4:3,
    // expected write-through and cache-disable, expected fill.
    logic [9:0] tab[5] = '{10'h235, 10'h332, 10'h079, 10'h082, 10'h242};
    always #4 clk = ~clk;
    cbac_top u_dut (.clk, .rst_b, .req_valid, .req_addr, .req_be, .req_read,
        .req_untranslated, .paging_en, .page_entry, .page_base_ctl,
        .fill_disable_bit, .bus_granted, .rdy_n, .cacheable_resp_n,
        .width_half_sel_n, .width_byte_sel_n, .addr_bit20_mask_n, .flush_n,
        .inv_strobe_n, .inv_addr, .req_ready, .address_strobe_n, .addr_out,
        .byte_en_n, .page_write_through, .pwt_oe, .page_cache_disable,
        .pcd_oe, .fill_active, .xfer_ack, .xfer_width, .req_done,
        .cache_flush, .lookup_valid, .lookup_addr, .inv_valid, .inv_addr_out);
    cbac_mem_model u_mem (.clk, .rst_b, .address_strobe_n, .cfg_w, .dly,
        .rdy_n, .width_half_sel_n, .width_byte_sel_n);
    // ==========================================================
    // Shared tasks
    task automatic chk(input bit ok, input string msg);
        tests_run++;
        if (!ok) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Called at a rising edge; returns one nanosecond after req_done.
    task automatic run_req(input logic [31:0] a, input logic rd);
        bit done;
        req_addr <= a;
        req_read <= rd;
        req_valid <= 1'b1;
        do @(posedge clk); while (!(req_ready === 1'b1 && !bus_granted));
        req_valid <= 1'b0;
        n_ack = 0;
        saw_fill = 1'b0;
        done = 1'b0;
        #1 la = lookup_valid ? lookup_addr : 'x;
        for (int i = 0; i < 300 && !done; i++) begin
            @(posedge clk);
            #1;
            if (xfer_ack === 1'b1) begin
                n_ack++;
                lw = xfer_width;
                if (n_ack == 1) be2 = byte_en_n;
            end
            if (fill_active === 1'b1) saw_fill = 1'b1;
            if (lookup_valid === 1'b1) la = lookup_addr;
            done = (req_done === 1'b1);
        end
        chk(done, "request hung");
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        cacheable_resp_n <= 1'b0;
        for (int w = 0; w < 4; w++) begin
            @(posedge clk);
            cfg_w <= w[1:0];
            dly <= 3'(w + 1);
            run_req(32'h0000_0104, 1'b1);
            chk(saw_fill && n_ack == fl[w], "fill count");
            chk(lw === ew[w], "width");
            @(posedge clk);
            run_req(32'h0000_0200, 1'b0);
            chk(!saw_fill && n_ack == sp[w], "split");
            chk(be2 === eb[w], "enables");
        end
        $display("test widths done");
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            {paging_en, req_untranslated, fill_disable_bit} <= tab[k][9:7];
            page_entry <= {7'h00, tab[k][6:5], 3'h0};
            page_base_ctl <= {7'h00, tab[k][4:3], 3'h0};
            run_req(32'h0000_0300, 1'b1);
            chk({page_write_through, page_cache_disable} === tab[k][2:1],
                "attr");
            chk(saw_fill === tab[k][0], "fill choice");
        end
        $display("test attributes done");
        @(posedge clk);
        {paging_en, req_untranslated, fill_disable_bit} <= 3'h0;
        cacheable_resp_n <= 1'b1;
        dly <= 3'h1;
        addr_bit20_mask_n <= 1'b0; // Paging off stands for real mode.
        run_req(32'h0010_0400, 1'b0); // Mask lags this request.
        chk(la[20] & addr_out[20], "early");
        @(posedge clk);
        run_req(32'h0010_0400, 1'b1);
        chk(la[20] === 1'b0 && addr_out[20] === 1'b0, "mask");
        @(posedge clk);
        inv_addr <= 28'h001_0000;
        inv_strobe_n <= 1'b0;
        @(posedge clk);
        inv_strobe_n <= 1'b1;
        #1 chk(inv_valid & inv_addr_out[20], "inv");
        $display("test mask done");
        @(posedge clk);
        flush_n <= 1'b0;
        @(posedge clk);
        flush_n <= 1'b1;
        #1 chk(cache_flush === 1'b1, "flush");
        @(posedge clk);
        #1 chk(cache_flush === 1'b0, "flush pulse");
        $display("test flush done");
        @(posedge clk);
        bus_granted <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(pwt_oe === 1'b0 && pcd_oe === 1'b0, "float");
        @(posedge clk);
        bus_granted <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(pwt_oe === 1'b1 && pcd_oe === 1'b1, "drive");
        $display("test bus hold done");
        close_out();
    end
    initial begin
        #100000;
        n_fail++;
        close_out();
    end
endmodule
